// [verilog/bdma_core.sv]
`timescale 1ns/10ps
module bdma_core #(
    parameter int         IMPL_BANKS = 16,
    parameter logic [7:0] FAST_SPLIT = bdma_pkg::FAST_SPLIT_DEFAULT
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 resetn_i,
    input  wire bdma_pkg::bdma_req_type req_i,
    input  wire logic [7:0]           literal_i,
    output bdma_pkg::bdma_rsp_type    rsp_o,
    output logic [7:0]                bank_select_o,
    output logic                      status_update_o
);
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic [5:0]  bank_q;
    logic [13:0] addr_d;
    logic        impl_d;
    logic        sfr_top;
    // one spare bank past the low banks holds the top bank, so it aliases nothing
    logic [7:0]  mem [0:(IMPL_BANKS+1)*256-1];

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic bank_impl(input logic [5:0] b);
        // top bank holds the special registers and is always present
        bank_impl = (32'(b) < IMPL_BANKS) || (b == bdma_pkg::FAST_SFR_BANK);
    endfunction

    // the address path serves full, banked and fast-window forms alike
    always_comb
    begin
        sfr_top = 1'b0;
        unique case (req_i.mode)
            bdma_pkg::BDMA_MODE_FULL:
                addr_d = req_i.full_addr;
            bdma_pkg::BDMA_MODE_BANKED:
                addr_d = {bank_q, req_i.offset};
            bdma_pkg::BDMA_MODE_FAST:
            begin
                sfr_top = req_i.offset >= FAST_SPLIT;
                addr_d = sfr_top ? {bdma_pkg::FAST_SFR_BANK, req_i.offset}
                                 : {bdma_pkg::FAST_GPR_BANK, req_i.offset};
            end
            default:
                addr_d = req_i.full_addr;
        endcase
        impl_d = bank_impl(addr_d[13:8]);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
            bank_q <= bdma_pkg::BANK_SELECT_RESET[5:0];
        else if (req_i.valid && req_i.load_bank)
            bank_q <= literal_i[5:0] & bdma_pkg::BANK_SELECT_MASK;
    end

    always_ff @(posedge clk_sys_i)
    begin
        // top bank storage stands in for the special registers here
        if (req_i.valid && req_i.write && !req_i.load_bank && impl_d)
            mem[(addr_d[13:8] == bdma_pkg::FAST_SFR_BANK)
                ? 32'(addr_d[7:0]) + IMPL_BANKS*256 : 32'(addr_d)] <= req_i.wdata;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_o           <= '0;
            bank_select_o   <= 8'h00;
            status_update_o <= 1'b0;
        end
        else
        begin
            rsp_o.valid       <= req_i.valid && !req_i.load_bank;
            rsp_o.implemented <= impl_d;
            rsp_o.addr        <= addr_d;
            if (req_i.valid && !req_i.write && !req_i.load_bank && impl_d)
                rsp_o.rdata <= mem[(addr_d[13:8] == bdma_pkg::FAST_SFR_BANK)
                    ? 32'(addr_d[7:0]) + IMPL_BANKS*256 : 32'(addr_d)];
            else
                rsp_o.rdata <= 8'h00;
            status_update_o <= req_i.valid && !req_i.load_bank;
            bank_select_o   <= {2'h0, (req_i.valid && req_i.load_bank)
                                ? literal_i[5:0] : bank_q};
        end
    end

    a_unimpl_read_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        rsp_o.valid && !rsp_o.implemented |-> rsp_o.rdata == 8'h00)
        else $error("unimplemented bank read not zero");
    a_bank_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        bank_select_o[7:6] == 2'h0)
        else $error("bank select upper bits set");
    a_load_bank: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && req_i.load_bank |=> bank_select_o == {2'h0, $past(literal_i[5:0])})
        else $error("bank select not loaded");
    a_status_always: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && !req_i.load_bank && !impl_d |=> status_update_o)
        else $error("status not updated");
    a_banked_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && !req_i.load_bank && req_i.mode == bdma_pkg::BDMA_MODE_BANKED
        |=> rsp_o.addr == {$past(bank_q), $past(req_i.offset)})
        else $error("banked address wrong");
    a_fast_gpr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && !req_i.load_bank && req_i.mode == bdma_pkg::BDMA_MODE_FAST
        && req_i.offset < FAST_SPLIT |=> rsp_o.addr[13:8] == 6'h00)
        else $error("fast window low part not bank zero");
    a_fast_sfr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && !req_i.load_bank && req_i.mode == bdma_pkg::BDMA_MODE_FAST
        && req_i.offset >= FAST_SPLIT |=> rsp_o.addr[13:8] == 6'h3f)
        else $error("fast window high part not top bank");
    a_full_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_i.valid && !req_i.load_bank && req_i.mode == bdma_pkg::BDMA_MODE_FULL
        |=> rsp_o.addr == $past(req_i.full_addr))
        else $error("full address not passed");
endmodule

// [verilog/bdma_pkg.sv]
package bdma_pkg;
    localparam int ADDR_W = 14;
    localparam int BANK_W = 6;
    localparam int OFFS_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_BANKS = 64;
    localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
    localparam logic [5:0] BANK_SELECT_MASK = 6'h3f;
    // fast window split: offsets below this go to bank 0, the rest to the top bank
    localparam logic [7:0] FAST_SPLIT_DEFAULT = 8'h60;
    localparam logic [5:0] FAST_SFR_BANK = 6'h3f;
    localparam logic [5:0] FAST_GPR_BANK = 6'h00;

    typedef enum logic [1:0] {
        BDMA_MODE_FULL,
        BDMA_MODE_BANKED,
        BDMA_MODE_FAST
    } bdma_mode_type;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              load_bank;
        bdma_mode_type     mode;
        logic [13:0]       full_addr;
        logic [7:0]        offset;
        logic [7:0]        wdata;
    } bdma_req_type;

    typedef struct packed {
        logic              valid;
        logic              implemented;
        logic [13:0]       addr;
        logic [7:0]        rdata;
    } bdma_rsp_type;
endpackage

// [test/bdma_core_model.sv]
`timescale 1ns/10ps
module bdma_core_model (
    input  wire logic                   clk_sys_i,
    input  wire bdma_pkg::bdma_rsp_type rsp_i,
    input  wire logic                   status_update_i,
    output bdma_pkg::bdma_req_type      req_o,
    output logic [7:0]                  literal_o
);
    initial
    begin
        req_o = '0;
        literal_o = 8'h00;
    end
    // called at a falling edge; valid drops after one cycle and an idle cycle follows
    task automatic xfer(input logic w, input logic lb, input bdma_pkg::bdma_mode_type m,
                        input logic [13:0] fa, input logic [7:0] off, input logic [7:0] d,
                        output bdma_pkg::bdma_rsp_type r, output logic st);
        req_o = '{1'b1, w, lb, m, fa, off, d};
        literal_o = d;
        @(negedge clk_sys_i);
        r = rsp_i;
        st = status_update_i;
        req_o.valid = 1'b0;
        @(negedge clk_sys_i);
    endtask
endmodule

// [test/banked_data_memory_addressing_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
module banked_data_memory_addressing_tb;
    logic                   clk_sys_i;
    logic                   resetn_i;
    bdma_pkg::bdma_req_type req;
    bdma_pkg::bdma_rsp_type rsp;
    bdma_pkg::bdma_rsp_type r;
    logic [7:0]             lit;
    logic [7:0]             bank;
    logic                   stat;
    logic                   st;
    int                     error_cnt = 0;
    int                     n_checks = 0;
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    bdma_core uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req), .literal_i(lit),
                   .rsp_o(rsp), .bank_select_o(bank), .status_update_o(stat));
    bdma_core_model core (.clk_sys_i(clk_sys_i), .rsp_i(rsp), .status_update_i(stat),
                          .req_o(req), .literal_o(lit));
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        resetn_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        core.xfer(1'b0, 1'b1, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h00, 8'hff, r, st);
        `CHK("bank select", 8'h3f, bank)
        `CHK("load rsp", 1'b0, r.valid)
        core.xfer(1'b0, 1'b1, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h00, 8'h01, r, st);
        core.xfer(1'b1, 1'b0, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h10, 8'ha5, r, st);
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h10, 8'h00, r, st);
        `CHK("banked addr", 14'h0110, r.addr)
        `CHK("banked data", 8'ha5, r.rdata)
        core.xfer(1'b0, 1'b1, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h00, 8'h21, r, st);
        core.xfer(1'b1, 1'b0, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h10, 8'h5a, r, st);
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_BANKED, 14'h0000, 8'h10, 8'h00, r, st);
        `CHK("unimpl data", 8'h00, r.rdata)
        `CHK("unimpl flag", 1'b0, r.implemented)
        `CHK("unimpl status", 1'b1, st)
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FULL, 14'h0110, 8'h00, 8'h00, r, st);
        `CHK("full data", 8'ha5, r.rdata)
        `CHK("full addr", 14'h0110, r.addr)
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FULL, 14'h2345, 8'h00, 8'h00, r, st);
        `CHK("full unimpl", 8'h00, r.rdata)
        core.xfer(1'b1, 1'b0, bdma_pkg::BDMA_MODE_FULL, 14'h0010, 8'h00, 8'h3c, r, st);
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FAST, 14'h0000, 8'h10, 8'h00, r, st);
        `CHK("fast data", 8'h3c, r.rdata)
        `CHK("fast low", {bdma_pkg::FAST_GPR_BANK, 8'h10}, r.addr)
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FAST, 14'h0000, 8'h80, 8'h00, r, st);
        `CHK("fast high", {bdma_pkg::FAST_SFR_BANK, 8'h80}, r.addr)
        core.xfer(1'b1, 1'b0, bdma_pkg::BDMA_MODE_FULL, 14'h0f80, 8'h00, 8'h11, r, st);
        core.xfer(1'b1, 1'b0, bdma_pkg::BDMA_MODE_FAST, 14'h0000, 8'h80, 8'h77, r, st);
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FULL, 14'h0f80, 8'h00, 8'h00, r, st);
        `CHK("bank 15 kept", 8'h11, r.rdata)
        core.xfer(1'b0, 1'b0, bdma_pkg::BDMA_MODE_FAST, 14'h0000, 8'h80, 8'h00, r, st);
        `CHK("top bank data", 8'h77, r.rdata)
        wrap_up();
    end
endmodule
